// file: rtl/sff_pkg.sv
// Shared constants and carriers for the serial-flash front end
package sff_pkg;
   // System clock and power-up write delay
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned PUW_NS = 10000;
   localparam int unsigned PUW_CYC = (PUW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Status word bit positions and values
   localparam int unsigned ST_WIP = 0;
   localparam int unsigned ST_WEL = 1;
   localparam int unsigned ST_BP0 = 2;
   localparam int unsigned ST_BP1 = 3;
   localparam int unsigned ST_TB = 5;
   localparam int unsigned ST_SRP = 7;
   localparam logic [7:0] ST_RESET = 8'h00;
   localparam logic [7:0] ST_NV_MASK = 8'hbc;
   // Instruction codes
   localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_DOUT = 8'h3b;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_CE_A = 8'h60;
   localparam logic [7:0] OP_SUSP = 8'h75;
   localparam logic [7:0] OP_REL = 8'hab;
   localparam logic [7:0] OP_PD = 8'hb9;
   localparam logic [7:0] OP_DIO = 8'hbb;
   localparam logic [7:0] OP_CE_B = 8'hc7;
   localparam logic [7:0] OP_BE64 = 8'hd8;
   // Bit counts at which phases end; one per serial clock edge, two per edge on dual input
   localparam logic [15:0] CNT_OP = 16'h0008;
   localparam logic [15:0] CNT_SR = 16'h0010;
   localparam logic [15:0] CNT_DIO_ADDR = 16'h0014;
   localparam logic [15:0] CNT_DIO_DATA = 16'h0018;
   localparam logic [15:0] CNT_ADDR = 16'h0020;
   localparam logic [15:0] CNT_FAST = 16'h0028;
   localparam logic [15:0] CNT_SAT = 16'hfff0;
   // Captured instruction and the operation handed to the array
   typedef struct packed {
      logic [7:0] op;
      logic [23:0] addr;
      logic [7:0] data;
      logic [15:0] cnt;
   } sff_cmd_s;
   typedef struct packed {
      logic [7:0] code;
      logic [23:0] addr;
      logic [7:0] data;
   } sff_op_s;
endpackage : sff_pkg

// file: rtl/sff_front_end.sv
// Serial-flash SPI front end: link decoder, status word and write gating
//
// What this block does
// - Single-line instruction, address and data bits sampled on rising serial clock.
// - Read data and status shifted out on falling serial clock edges.
// - Works with serial clock idle low or high, modes 0 and 3 only.
// - Dual read opcodes turn both data lines into two-bit-per-clock lines.
// - Pause starts at hold fall if clock low, else after next falling edge.
// - Pause ends at hold rise if clock low, else after next falling edge.
// - While paused outputs float, inputs ignored, partial instruction kept.
// - Below supply trip level nothing runs and no instruction is taken.
// - Write-type instructions refused for a delay after supply recovers.
// - Permit latch starts at zero; write-type instructions need it set.
// - Write enable sets permit latch; disable and write-types clear it.
// - Permit latch cleared when a program, erase or status write ends.
// - Busy bit high from write-type start until its operation finishes.
// - While busy only status read and suspend are honoured.
// - After power-down only release power-down is honoured.
// - Status writes gated by lock bit, permit latch and guard pin.
// - Region guard bits make part or all of the array read-only.
// - Status word bits default to zero.
// - Guard bits decode to none, upper half, lower half or whole array.
// - Lock bit set with guard pin low refuses status writes.
// - Opcode arrives first, most significant bit first, after select falls.
// - Write-type instructions ending off a byte boundary are ignored.
`timescale 1ns/1ps
`default_nettype none
module sff_front_end #(
   parameter int unsigned PUW_CYCLES = sff_pkg::PUW_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic supply_ok,
   input wire logic dual_line_0_in,
   output logic dual_line_0_out,
   output logic dual_line_0_oe_n,
   input wire logic dual_line_1_in,
   output logic dual_line_1_out,
   output logic dual_line_1_oe_n,
   input wire logic op_done,
   input wire logic [7:0] rd_data,
   output logic op_start,
   output sff_pkg::sff_op_s op_cmd,
   output logic rd_req,
   output logic [23:0] rd_addr,
   output logic [7:0] status_word,
   output logic powered_down
);
   import sff_pkg::*;

   // First output edge count of a read, zero when the read is not honoured
   function automatic logic [15:0] sff_rd_start(input logic [7:0] op, input logic busy, input logic deny);
      logic [15:0] s;
      s = 16'h0000;
      if (!deny) begin
         case (op)
            OP_RDSR: s = CNT_OP;
            OP_READ: s = busy ? 16'h0000 : CNT_ADDR;
            OP_FAST, OP_DOUT: s = busy ? 16'h0000 : CNT_FAST;
            OP_DIO: s = busy ? 16'h0000 : CNT_DIO_DATA;
            default: s = 16'h0000;
         endcase
      end
      return s;
   endfunction : sff_rd_start

   // True where a new output byte begins
   function automatic logic sff_bound(input logic [15:0] cnt, input logic [15:0] start, input logic dual);
      logic [15:0] ofs;
      ofs = cnt - start;
      return (start != 16'h0000) && (cnt >= start) && (dual ? (ofs[1:0] == 2'b00) : (ofs[2:0] == 3'b000));
   endfunction : sff_bound

   // ---------------- Link domain (serial clock) ----------------
   logic fresh_r;
   logic [31:0] sh_r;
   logic [31:0] sh_nxt;
   sff_cmd_s cmd_r;
   sff_cmd_s cmd_nxt;
   logic frm_tog_r;
   logic req_tog_r;
   logic [23:0] req_addr_r;
   logic pause_r;
   logic [7:0] tx_r;
   logic oe0_n_r;
   logic oe1_n_r;
   logic [7:0] lst_s1_r;
   logic [7:0] lst_s2_r;
   logic [1:0] lden_s1_r;
   logic [1:0] lden_s2_r;
   logic deny_r;
   logic [7:0] rd_byte_r;
   logic [7:0] st_r;

   // Decoder state seen at a rising edge
   wire logic [15:0] cnt_base = fresh_r ? 16'h0000 : cmd_r.cnt;
   wire logic dual_in = !fresh_r && (cmd_r.op == OP_DIO) && (cmd_r.cnt >= CNT_OP)
                        && (cmd_r.cnt < CNT_DIO_DATA);
   wire logic [15:0] cnt_nxt = (cnt_base >= CNT_SAT) ? cnt_base : cnt_base + (dual_in ? 16'h0002 : 16'h0001);
   wire logic [7:0] op_now = (cnt_nxt > CNT_OP) ? cmd_r.op : sh_nxt[7:0];
   wire logic [15:0] start_pos = sff_rd_start(op_now, lst_s2_r[ST_WIP], lden_s2_r[1]);
   wire logic dual_pos = (op_now == OP_DOUT) || (op_now == OP_DIO);
   wire logic req_go = sff_bound(cnt_nxt, start_pos, dual_pos) && (op_now != OP_RDSR);
   wire logic [23:0] first_addr = (start_pos == CNT_ADDR) ? sh_nxt[23:0] : cmd_r.addr;
   // Decoder state seen at a falling edge
   wire logic [15:0] start_neg = sff_rd_start(cmd_r.op, lst_s2_r[ST_WIP], lden_s2_r[1]);
   wire logic dual_neg = (cmd_r.op == OP_DOUT) || (cmd_r.op == OP_DIO);
   wire logic bound_neg = sff_bound(cmd_r.cnt, start_neg, dual_neg);
   wire logic [7:0] tx_src = (cmd_r.op == OP_RDSR) ? lst_s2_r : rd_byte_r;
   // Pause follows the pin while the clock is low, else the last falling edge
   wire logic paused = spi_clk ? pause_r : !hold_n;

   // Next shift and capture values; one or two bits per edge, MSB first
   always_comb begin
      sh_nxt = dual_in ? {sh_r[29:0], dual_line_1_in, dual_line_0_in} : {sh_r[30:0], dual_line_0_in};
      cmd_nxt = cmd_r;
      cmd_nxt.cnt = cnt_nxt;
      if (cnt_nxt == CNT_OP) begin
         cmd_nxt.op = sh_nxt[7:0];
      end
      if ((cnt_nxt == CNT_ADDR) || ((cnt_nxt == CNT_DIO_ADDR) && (cmd_r.op == OP_DIO))) begin
         cmd_nxt.addr = sh_nxt[23:0];
      end
      if (((cnt_nxt == CNT_SR) && (cmd_r.op == OP_STATUS_WRITE_CMD)) || ((cnt_nxt == CNT_FAST) && (cmd_r.op == OP_PP))) begin
         cmd_nxt.data = sh_nxt[7:0];
      end
   end

   // Select high restarts decoding; first unpaused edge clears it
   always_ff @(posedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         fresh_r <= 1'b1;
      end else if (hold_n) begin
         fresh_r <= 1'b0;
      end
   end

   // Sampling on rising edges; held during a pause so nothing is lost
   always_ff @(posedge spi_clk) begin
      if (hold_n) begin
         sh_r <= sh_nxt;
         cmd_r <= cmd_nxt;
      end
   end

   // Frame marker and array read requests toward the system clock
   always_ff @(posedge spi_clk or posedge reset) begin
      if (reset) begin
         frm_tog_r <= 1'b0;
         req_tog_r <= 1'b0;
         req_addr_r <= 24'h000000;
      end else if (hold_n) begin
         frm_tog_r <= frm_tog_r ^ fresh_r;
         if (req_go) begin
            req_tog_r <= !req_tog_r;
            req_addr_r <= (cnt_nxt == start_pos) ? first_addr : req_addr_r + 24'h000001;
         end
      end
   end

   // Status and deny levels into the link clock; stale only for two edges
   always_ff @(posedge spi_clk) begin
      lst_s1_r <= st_r;
      lst_s2_r <= lst_s1_r;
      lden_s1_r <= {deny_r, 1'b0};
      lden_s2_r <= lden_s1_r;
   end

   // Output shifter on falling edges in either idle clock level; outputs float with select high
   always_ff @(negedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         pause_r <= 1'b0;
         tx_r <= 8'h00;
         oe0_n_r <= 1'b1;
         oe1_n_r <= 1'b1;
      end else begin
         pause_r <= !hold_n;
         if (!pause_r && !fresh_r) begin
            if (bound_neg) begin
               tx_r <= tx_src;
               oe1_n_r <= 1'b0;
               oe0_n_r <= !dual_neg;
            end else begin
               tx_r <= dual_neg ? {tx_r[5:0], 2'b00} : {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   assign dual_line_1_out = tx_r[7];
   assign dual_line_0_out = tx_r[6];
   // Pause floats the lines at once with the clock low, else after the next falling edge; that is why the enables are gated
   assign dual_line_1_oe_n = oe1_n_r | paused;
   assign dual_line_0_oe_n = oe0_n_r | paused;

   // ---------------- System clock domain ----------------
   logic [4:0] sy1_r;
   logic [4:0] sy2_r;
   logic [1:0] edge_r;
   logic frm_seen_r;
   logic [12:0] pu_cnt_r;
   logic pd_r;
   logic rd_req_r;
   logic rd_req_d_r;
   logic [23:0] rd_addr_r;
   logic op_start_r;
   sff_op_s op_r;
   logic [7:0] st_nxt;

   wire logic cs_s = sy2_r[4];
   wire logic sup_s = sy2_r[3];
   wire logic wp_s = sy2_r[2];
   wire logic por_act = !sup_s;
   wire logic pu_done = (pu_cnt_r >= PUW_CYCLES[12:0]);
   wire logic frame_new = cs_s && !edge_r[1] && (sy2_r[0] != frm_seen_r) && !por_act;
   wire logic aligned = (cmd_r.cnt[2:0] == 3'b000);
   wire logic operation_in_progress = st_r[ST_WIP];
   wire logic write_permit_latch = st_r[ST_WEL];
   wire logic idle = !operation_in_progress && !pd_r;
   wire logic is_pp = (cmd_r.op == OP_PP);
   wire logic is_blk = (cmd_r.op == OP_SE) || (cmd_r.op == OP_BE32) || (cmd_r.op == OP_BE64);
   wire logic is_ce = (cmd_r.op == OP_CE_A) || (cmd_r.op == OP_CE_B);
   wire logic len_ok = is_ce || (is_blk && (cmd_r.cnt >= CNT_ADDR)) || (is_pp && (cmd_r.cnt >= CNT_FAST));
   // Guarded region: none, upper half, lower half or all
   wire logic any_prot = st_r[ST_BP1] | st_r[ST_BP0];
   wire logic hit_prot = st_r[ST_BP1] | (st_r[ST_BP0] & (cmd_r.addr[15] ^ st_r[ST_TB]));
   wire logic prot = is_ce ? any_prot : hit_prot;
   wire logic wr_gate = frame_new && pu_done && write_permit_latch && aligned && idle;
   wire logic acc_arr = wr_gate && len_ok && !prot;
   wire logic sr_lock = st_r[ST_SRP] && !wp_s;
   wire logic acc_status_write_cmd = wr_gate && (cmd_r.op == OP_STATUS_WRITE_CMD) && (cmd_r.cnt >= CNT_SR) && !sr_lock;
   wire logic acc_wren = frame_new && (cmd_r.op == OP_WREN) && pu_done && aligned && idle;
   wire logic acc_wrdi = frame_new && (cmd_r.op == OP_WRDI) && aligned && idle;
   wire logic acc_pd = frame_new && (cmd_r.op == OP_PD) && idle;
   wire logic acc_rel = frame_new && (cmd_r.op == OP_REL) && pd_r && !operation_in_progress;
   wire logic acc_susp = frame_new && (cmd_r.op == OP_SUSP) && operation_in_progress && !pd_r;

   // Status word next value; permit latch drops when the operation ends
   always_comb begin
      st_nxt = st_r;
      if (por_act) begin
         st_nxt[ST_WEL] = 1'b0;
      end
      if (op_done && operation_in_progress) begin
         st_nxt[ST_WIP] = 1'b0;
         st_nxt[ST_WEL] = 1'b0;
      end
      if (acc_wren) begin
         st_nxt[ST_WEL] = 1'b1;
      end
      if (acc_wrdi) begin
         st_nxt[ST_WEL] = 1'b0;
      end
      if (acc_status_write_cmd) begin
         st_nxt = (cmd_r.data & ST_NV_MASK) | (st_r & ~ST_NV_MASK);
         st_nxt[ST_WIP] = 1'b1;
      end
      if (acc_arr) begin
         st_nxt[ST_WIP] = 1'b1;
      end
   end

   // Two-flop synchronisers: select, supply, guard pin, request, frame
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sy1_r <= 5'h10;
         sy2_r <= 5'h10;
         edge_r <= 2'b10;
      end else begin
         sy1_r <= {cs_n, supply_ok, wp_n, req_tog_r, frm_tog_r};
         sy2_r <= sy1_r;
         edge_r <= {sy2_r[4], sy2_r[1]};
      end
   end

   // Power-up write delay, restarted whenever supply drops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pu_cnt_r <= 13'h0000;
      end else if (por_act) begin
         pu_cnt_r <= 13'h0000;
      end else if (!pu_done) begin
         pu_cnt_r <= pu_cnt_r + 13'h0001;
      end
   end

   // Status, power-down and frame bookkeeping
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st_r <= ST_RESET;
         pd_r <= 1'b0;
         frm_seen_r <= 1'b0;
         deny_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         pd_r <= !por_act && ((pd_r && !acc_rel) || acc_pd);
         frm_seen_r <= cs_s ? sy2_r[0] : frm_seen_r;
         deny_r <= por_act || pd_r;
      end
   end

   // Operation launch toward the array, one-cycle pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         op_start_r <= 1'b0;
         op_r <= '0;
      end else begin
         op_start_r <= acc_arr || acc_status_write_cmd || acc_susp;
         if (acc_arr || acc_status_write_cmd || acc_susp) begin
            op_r <= '{code: cmd_r.op, addr: cmd_r.addr, data: cmd_r.data};
         end
      end
   end

   // Array read service; answer must arrive the cycle after the request
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_req_r <= 1'b0;
         rd_req_d_r <= 1'b0;
         rd_addr_r <= 24'h000000;
         rd_byte_r <= 8'h00;
      end else begin
         rd_req_r <= sy2_r[1] ^ edge_r[0];
         rd_req_d_r <= rd_req_r;
         if (sy2_r[1] ^ edge_r[0]) begin
            rd_addr_r <= req_addr_r;
         end
         if (rd_req_d_r) begin
            rd_byte_r <= rd_data;
         end
      end
   end

   assign op_start = op_start_r;
   assign op_cmd = op_r;
   assign rd_req = rd_req_r;
   assign rd_addr = rd_addr_r;
   assign status_word = st_r;
   assign powered_down = pd_r;

   // ---------------- Checks ----------------
   a_wel_por: assert property (@(posedge clock) disable iff (reset)
      por_act |=> !st_r[ST_WEL]) else $error("permit latch set under power-on reset");
   a_wren_delay: assert property (@(posedge clock) disable iff (reset)
      (frame_new && (cmd_r.op == OP_WREN) && !pu_done) |=> !st_r[ST_WEL]) else $error("enable taken in delay");
   a_busy_start: assert property (@(posedge clock) disable iff (reset)
      acc_arr |=> (st_r[ST_WIP] && op_start && !$past(st_r[ST_WIP]))) else $error("busy not raised");
   a_done_clear: assert property (@(posedge clock) disable iff (reset)
      (op_done && operation_in_progress && !por_act) |=> (!st_r[ST_WIP] && !st_r[ST_WEL])) else $error("done left bits set");
   a_busy_ignore: assert property (@(posedge clock) disable iff (reset)
      (operation_in_progress && !op_done && frame_new) |=> $stable(st_r[7:1]) && !$past(acc_wren)) else $error("busy took a command");
   a_lock_refuse: assert property (@(posedge clock) disable iff (reset)
      (frame_new && (cmd_r.op == OP_STATUS_WRITE_CMD) && st_r[ST_SRP] && !wp_s) |=> $stable(st_r & ST_NV_MASK))
      else $error("locked status written");
   a_unaligned_drop: assert property (@(posedge clock) disable iff (reset)
      (frame_new && (is_pp || is_blk || is_ce) && !aligned) |=> !op_start) else $error("partial byte accepted");
   a_pd_hold: assert property (@(posedge clock) disable iff (reset)
      (pd_r && !por_act && frame_new && (cmd_r.op != OP_REL)) |=> pd_r ##1 !op_start) else $error("power-down left");
   a_prot_refuse: assert property (@(posedge clock) disable iff (reset)
      (frame_new && (is_pp || is_blk) && st_r[ST_BP1] && !operation_in_progress) |=> !op_start && !st_r[ST_WIP])
      else $error("guarded write");
   c_program: cover property (@(posedge clock) disable iff (reset) acc_arr && is_pp);
   c_status_write: cover property (@(posedge clock) disable iff (reset) acc_status_write_cmd);
   c_read_req: cover property (@(posedge clock) disable iff (reset) rd_req_r ##[1:40] rd_req_r);
   c_power_down: cover property (@(posedge clock) disable iff (reset) acc_pd ##[1:1000] acc_rel);
endmodule : sff_front_end
`default_nettype wire

// file: dv/sff_master_model.sv
// Behavioural bus master that drives the serial link of the front end
`timescale 1ns/1ps
`default_nettype none
module sff_master_model (
   output var logic spi_clk,
   output var logic cs_n,
   output var logic hold_n,
   output var logic mo0,
   output var logic mo1,
   input wire logic line0,
   input wire logic line1
);
   localparam realtime HALF = 62.5;
   // Idle: deselected, clock parked low
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      hold_n = 1'b1;
      mo0 = 1'b0;
      mo1 = 1'b0;
   end
   // Select with the clock already at its idle level for the mode
   task automatic start(input logic mode3);
      spi_clk = mode3;
      #HALF;
      cs_n = 1'b0;
      #HALF;
   endtask : start
   // Pause control; select stays low the whole time
   task automatic pause(input logic p);
      hold_n = !p;
   endtask : pause
   // One clock: fall, change data, rise, sample both lines
   task automatic clk_bit(input logic b, input logic drive, output logic [1:0] got);
      spi_clk = 1'b0;
      mo0 = drive ? b : ~mo0;  // Released line toggles, never holds
      mo1 = ~mo1;
      #HALF;
      spi_clk = 1'b1;
      got = {line1, line0};
      #HALF;
   endtask : clk_bit
   // Park the clock, deselect, give the device time to act
   task automatic stop(input logic mode3);
      spi_clk = mode3;
      #HALF;
      cs_n = 1'b1;
      #(HALF * 4);
   endtask : stop
   // Whole frame: n bits MSB first, then nrd read clocks, single or dual
   task automatic frame(input logic mode3, input int n, input logic [63:0] tx, input int nrd,
                        input logic dual, output logic [7:0] rx);
      logic [1:0] g;
      start(mode3);
      for (int i = 0; i < n; i++) clk_bit(tx[63 - i], 1'b1, g);
      rx = 8'h00;
      for (int i = 0; i < nrd; i++) begin
         clk_bit(1'b0, 1'b0, g);
         rx = dual ? {rx[5:0], g} : {rx[6:0], g[1]};
      end
      stop(mode3);
   endtask : frame
endmodule : sff_master_model
`default_nettype wire

// file: dv/serial_flash_spi_front_end_test.sv
// Self-checking testbench for the serial-flash front end
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_front_end_test;
   import sff_pkg::*;
   localparam int PUW = 400;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic wp_n = 1'b1;
   logic supply_ok = 1'b0;
   logic op_done = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic spi_clk, cs_n, hold_n, mo0, mo1, o0, oe0_n, o1, oe1_n, op_start, rd_req, powered_down;
   logic drove = 1'b0;
   logic [23:0] rd_addr;
   logic [7:0] status_word, rx;
   sff_op_s op_cmd, last_op;
   int err_count = 0;
   int total_checks = 0;
   int n_ops = 0;
   // Wire levels: device output while its enable is low, else the master's drive
   wire logic line0 = !oe0_n ? o0 : mo0;
   wire logic line1 = !oe1_n ? o1 : mo1;
   sff_front_end #(.PUW_CYCLES(PUW)) sff_front_end_i (
      .clock(clock), .reset(reset), .spi_clk(spi_clk), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
      .supply_ok(supply_ok), .dual_line_0_in(line0), .dual_line_0_out(o0), .dual_line_0_oe_n(oe0_n),
      .dual_line_1_in(line1), .dual_line_1_out(o1), .dual_line_1_oe_n(oe1_n), .op_done(op_done),
      .rd_data(rd_data), .op_start(op_start), .op_cmd(op_cmd), .rd_req(rd_req), .rd_addr(rd_addr),
      .status_word(status_word), .powered_down(powered_down));
   sff_master_model sff_master_model_i (.spi_clk(spi_clk), .cs_n(cs_n), .hold_n(hold_n), .mo0(mo0),
      .mo1(mo1), .line0(line0), .line1(line1));
   // System clock, 5 ns period
   always #2.5 clock = ~clock;
   // Array stand-in: data from address, log of started operations
   always @(posedge clock) begin
      if (rd_req === 1'b1) rd_data <= rd_addr[7:0] ^ 8'h5a;
      if (op_start === 1'b1) begin
         last_op <= op_cmd;
         n_ops <= n_ops + 1;
      end
   end
   // Sticky: serial output was ever enabled
   always @(negedge oe1_n) drove = 1'b1;
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task automatic send(input int n, input logic [63:0] tx);
      sff_master_model_i.frame(1'b0, n, tx, 0, 1'b0, rx);
   endtask : send
   task automatic rdsr(input logic m3);
      sff_master_model_i.frame(m3, 8, {OP_RDSR, 56'h0}, 8, 1'b0, rx);
   endtask : rdsr
   // Completion pulse from the array, then let the status settle
   task automatic finish_op;
      @(posedge clock) op_done <= 1'b1;
      @(posedge clock) op_done <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : finish_op
   // Defaults, supply lockout, power-up delay, latch set and clear
   task automatic t_power;
      chk_byte(status_word, ST_RESET);
      chk_bit(powered_down, 1'b0);
      rdsr(1'b0);
      chk_bit(drove, 1'b0);
      @(posedge clock) supply_ok <= 1'b1;
      send(8, {OP_WREN, 56'h0});
      chk_byte(status_word, 8'h00);
      repeat (PUW) @(posedge clock);
      send(7, {OP_WREN, 56'h0});
      chk_byte(status_word, 8'h00);
      send(8, {OP_WREN, 56'h0});
      rdsr(1'b0);
      chk_byte(rx, 8'h02);
      send(8, {OP_WRDI, 56'h0});
      chk_byte(status_word, 8'h00);
   endtask : t_power
   // Program refused without permit, then accepted, busy filtering, completion
   task automatic t_program;
      int n0;
      n0 = n_ops;
      send(40, {OP_PP, 24'h000123, 8'h3c, 24'h0});
      chk_byte(status_word, 8'h00);
      chk_byte(8'(n_ops - n0), 8'h00);
      send(8, {OP_WREN, 56'h0});
      send(39, {OP_PP, 24'h000123, 8'h3c, 24'h0});
      chk_byte(status_word, 8'h02);
      send(40, {OP_PP, 24'h000123, 8'h3c, 24'h0});
      chk_byte(status_word, 8'h03);
      chk_byte(last_op.code, OP_PP);
      chk_byte(last_op.addr[7:0], 8'h23);
      chk_byte(last_op.data, 8'h3c);
      send(8, {OP_WRDI, 56'h0});
      rdsr(1'b0);
      chk_byte(rx, 8'h03);
      finish_op;
      chk_byte(status_word, 8'h00);
   endtask : t_program
   // Status write, region guard decode, lock bit with guard pin
   task automatic t_protect;
      int n0;
      send(8, {OP_WREN, 56'h0});
      send(16, {OP_STATUS_WRITE_CMD, 8'ha4, 48'h0});
      chk_byte(status_word, 8'ha7);
      finish_op;
      chk_byte(status_word, 8'ha4);
      n0 = n_ops;
      send(8, {OP_WREN, 56'h0});
      send(32, {OP_SE, 24'h000100, 32'h0});
      chk_byte(status_word, 8'ha6);
      chk_byte(8'(n_ops - n0), 8'h00);
      send(32, {OP_SE, 24'h008000, 32'h0});
      chk_byte(status_word, 8'ha7);
      finish_op;
      @(posedge clock) wp_n <= 1'b0;
      send(8, {OP_WREN, 56'h0});
      send(16, {OP_STATUS_WRITE_CMD, 8'h00, 48'h0});
      chk_byte(status_word, 8'ha6);
      @(posedge clock) wp_n <= 1'b1;
      repeat (4) @(posedge clock);
      send(16, {OP_STATUS_WRITE_CMD, 8'h08, 48'h0});
      chk_byte(status_word, 8'h0b);
      finish_op;
      chk_byte(status_word, 8'h08);
      send(8, {OP_WREN, 56'h0});
      send(32, {OP_SE, 24'h008000, 32'h0});
      chk_byte(status_word, 8'h0a);
      send(16, {OP_STATUS_WRITE_CMD, 8'h00, 48'h0});
      chk_byte(status_word, 8'h03);
      finish_op;
      chk_byte(status_word, 8'h00);
   endtask : t_protect
   // Power-down filters everything but release
   task automatic t_sleep;
      send(8, {OP_PD, 56'h0});
      chk_bit(powered_down, 1'b1);
      send(8, {OP_WREN, 56'h0});
      drove = 1'b0;
      rdsr(1'b0);
      chk_bit(drove, 1'b0);
      chk_byte(status_word, 8'h00);
      send(8, {OP_REL, 56'h0});
      chk_bit(powered_down, 1'b0);
   endtask : t_sleep
   // Mode 3 status, single read, dual-output read
   task automatic t_reads;
      send(8, {OP_WREN, 56'h0});
      rdsr(1'b1);
      chk_byte(rx, 8'h02);
      send(8, {OP_WRDI, 56'h0});
      sff_master_model_i.frame(1'b0, 32, {OP_READ, 24'h000010, 32'h0}, 8, 1'b0, rx);
      chk_byte(rx, 8'h4a);
      sff_master_model_i.frame(1'b1, 40, {OP_DOUT, 24'h000021, 32'h0}, 4, 1'b1, rx);
      chk_byte(rx, 8'h7b);
   endtask : t_reads
   // Pause mid-opcode with the clock high; junk clocks must be ignored
   task automatic t_hold;
      logic [1:0] g;
      send(8, {OP_WREN, 56'h0});
      sff_master_model_i.start(1'b0);
      for (int i = 0; i < 4; i++) sff_master_model_i.clk_bit(OP_RDSR[7 - i], 1'b1, g);
      sff_master_model_i.pause(1'b1);
      for (int i = 0; i < 3; i++) sff_master_model_i.clk_bit(1'b1, 1'b1, g);
      chk_bit(oe1_n, 1'b1);
      sff_master_model_i.pause(1'b0);
      for (int i = 4; i < 8; i++) sff_master_model_i.clk_bit(OP_RDSR[7 - i], 1'b1, g);
      rx = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sff_master_model_i.clk_bit(1'b0, 1'b0, g);
         rx = {rx[6:0], g[1]};
      end
      sff_master_model_i.stop(1'b0);
      chk_byte(rx, 8'h02);
      send(8, {OP_WRDI, 56'h0});
   endtask : t_hold
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   // Main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      t_power;
      t_program;
      t_protect;
      t_sleep;
      t_reads;
      t_hold;
      test_done;
   end
   // Watchdog, well beyond the expected run length
   initial begin
      repeat (80000) @(posedge clock);
      err_count++;
      test_done;
   end
endmodule : serial_flash_spi_front_end_test
`default_nettype wire
